// File: hdl/acc_conv_ctrl.sv
// Converter control sequencer: registers, triggers, sleep and completion
//
// What this block does
// - The converter stays idle unless converter_on is one, and only then can it start.
// - Writing one to convert_go_done clears both result bytes and starts a conversion.
// - At completion go is cleared and the done flag is set in the same cycle.
// - Clearing go early abandons the conversion and keeps the previous result.
// - Reset returns all registers to reset values, turns off and cancels work.
// - With the dedicated RC clock the start waits one extra instruction cycle.
// - In sleep with the RC clock and interrupt enabled, completion raises wake.
// - In sleep with interrupt disabled the converter powers down after completion.
// - With another clock, sleep aborts the conversion and powers down, on stays set.
// - A rising edge of the selected trigger sets go and starts a conversion.
// - A four-bit field in converter_control_2 selects the trigger source.
`timescale 1ns/1ps
`default_nettype none
module acc_conv_ctrl
	import acc_pkg::*;
#(
	parameter int DELAY_CYC = acc_pkg::INSN_CYCLES
) (
	input  wire logic                        ref_clk,
	input  wire logic                        rst_n,
	input  wire acc_pkg::acc_bus_type        bus,
	output logic      [acc_pkg::DATA_W-1:0]  rdData,
	input  wire logic                        trigCcu1,
	input  wire logic                        trigCcu2,
	input  wire logic                        trigPsc1,
	input  wire logic                        trigPsc2,
	input  wire acc_pkg::acc_ana_type        ana,
	output acc_pkg::acc_cmd_type             cmd,
	output logic                             analogPower,
	output logic                             wakeReq,
	output logic                             irq
);
	import acc_pkg::*;

	localparam int CNT_W = $clog2(DELAY_CYC + 1);
	localparam logic [CNT_W-1:0] DELAY_LOAD = CNT_W'(DELAY_CYC);
	localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

	typedef struct packed {
		acc_state_type     state;
		logic [CNT_W-1:0]  cnt;
		logic              convOn;
		logic              goBit;
		logic              rcClk;
		logic [TSEL_W-1:0] tsel;
		logic [RES_W-1:0]  result;
		logic [RES_W-1:0]  prevRes;
		logic [STAT_W-1:0] stat;
		logic [STAT_W-1:0] mask;
		logic              sleepMode;
		logic              powerDown;
		logic [DATA_W-1:0] rd;
		logic              start;
		logic              abort;
		logic              power;
		logic              wake;
		logic              irq;
	} acc_regs_type;

	acc_regs_type r_r;
	acc_regs_type r_nxt;
	logic [TRIG_N-1:0] trigRise;
	logic              selRise;

	function automatic logic isWr(input acc_bus_type b,
		input logic [ADDR_W-1:0] a);
		return b.wrEn && (b.addr == a);
	endfunction

	function automatic logic isRd(input acc_bus_type b,
		input logic [ADDR_W-1:0] a);
		return b.rdEn && (b.addr == a);
	endfunction

	acc_trig_sync #(
		.N(TRIG_N)
	) u_sync (
		.ref_clk  (ref_clk),
		.rst_n    (rst_n),
		.trigIn   ({trigPsc2, trigPsc1, trigCcu2, trigCcu1}),
		.trigRise (trigRise)
	);

	// Unlisted select codes never trigger
	always_comb begin
		unique case (r_r.tsel)
			TSEL_CCU1: selRise = trigRise[0];
			TSEL_CCU2: selRise = trigRise[1];
			TSEL_PSC1: selRise = trigRise[2];
			TSEL_PSC2: selRise = trigRise[3];
			default:   selRise = 1'b0;
		endcase
	end

	always_comb begin
		logic goWr;
		logic goSet;
		logic goClr;
		logic busy;
		logic live;
		logic [STAT_W-1:0] ev;
		goWr  = 1'b0;
		goSet = 1'b0;
		goClr = 1'b0;
		busy  = 1'b0;
		live  = 1'b0;
		ev    = '0;
		r_nxt       = r_r;
		r_nxt.start = 1'b0;
		r_nxt.abort = 1'b0;
		r_nxt.wake  = 1'b0;

		// Register writes
		if (isWr(bus, ADDR_CTRL0)) begin
			r_nxt.convOn = bus.wrData[CTRL0_ON];
			r_nxt.rcClk  = bus.wrData[CTRL0_RC];
			goWr  = 1'b1;
			goSet = bus.wrData[CTRL0_GO];
			goClr = !bus.wrData[CTRL0_GO];
			if (bus.wrData[CTRL0_ON]) begin
				r_nxt.powerDown = 1'b0;
			end
		end
		if (isWr(bus, ADDR_CTRL2)) begin
			r_nxt.tsel = bus.wrData[CTRL2_TSEL_LO +: TSEL_W];
		end
		if (isWr(bus, ADDR_MASK)) begin
			r_nxt.mask = bus.wrData[STAT_W-1:0];
		end
		if (isWr(bus, ADDR_SLEEP)) begin
			r_nxt.sleepMode = bus.wrData[SLEEP_BIT];
		end

		// Hardware trigger acts only on an idle, enabled converter
		if (selRise && r_r.convOn && !r_r.powerDown &&
			r_r.state == CS_IDLE) begin
			goSet = 1'b1;
			goClr = 1'b0;
		end
		live = r_nxt.convOn && !r_nxt.powerDown;

		unique case (r_r.state)
			CS_IDLE: begin
				r_nxt.goBit = 1'b0;
				if (goSet && live) begin
					r_nxt.goBit  = 1'b1;
					r_nxt.result = '0;
					// Go clears the result, so keep the old one for an abort
					r_nxt.prevRes = r_r.result;
					if (r_nxt.rcClk) begin
						r_nxt.state = CS_DELAY;
						r_nxt.cnt   = DELAY_LOAD;
					end else begin
						r_nxt.state = CS_BUSY;
						r_nxt.start = 1'b1;
					end
				end
			end
			CS_DELAY: begin
				busy = 1'b1;
				r_nxt.cnt = r_r.cnt - CNT_ONE;
				if (r_r.cnt == CNT_ONE) begin
					r_nxt.state = CS_BUSY;
					r_nxt.start = 1'b1;
				end
			end
			CS_BUSY: begin
				busy = 1'b1;
				if (ana.done) begin
					r_nxt.state  = CS_IDLE;
					r_nxt.goBit  = 1'b0;
					r_nxt.result = ana.result;
					ev[STAT_DONE] = 1'b1;
					if (r_r.sleepMode) begin
						if (r_r.mask[STAT_DONE]) begin
							r_nxt.wake = 1'b1;
						end else begin
							r_nxt.powerDown = 1'b1;
						end
					end
				end
			end
		endcase

		// Early clear, switch-off or non-RC sleep cancels; result is kept
		if (busy && !ana.done) begin
			if ((goWr && goClr) || !r_nxt.convOn) begin
				r_nxt.state = CS_IDLE;
				r_nxt.goBit = 1'b0;
				r_nxt.abort = 1'b1;
				r_nxt.result = r_r.prevRes;
				r_nxt.start = 1'b0;
				ev[STAT_ABRT] = 1'b1;
			end else if (r_nxt.sleepMode && !r_r.rcClk) begin
				r_nxt.state = CS_IDLE;
				r_nxt.goBit = 1'b0;
				r_nxt.abort = 1'b1;
				r_nxt.start = 1'b0;
				r_nxt.powerDown = 1'b1;
				r_nxt.result = r_r.prevRes;
				ev[STAT_ABRT] = 1'b1;
			end
		end
		if (r_nxt.sleepMode && !r_nxt.rcClk) begin
			r_nxt.powerDown = 1'b1;
		end
		if (!r_nxt.sleepMode && r_r.sleepMode) begin
			r_nxt.powerDown = 1'b0;
		end

		// Read data; a status read clears, but a new event wins
		r_nxt.rd = ZERO_BYTE;
		if (bus.rdEn) begin
			unique case (bus.addr)
				ADDR_CTRL0: begin
					r_nxt.rd[CTRL0_ON] = r_r.convOn;
					r_nxt.rd[CTRL0_GO] = r_r.goBit;
					r_nxt.rd[CTRL0_RC] = r_r.rcClk;
				end
				ADDR_CTRL2: r_nxt.rd[TSEL_W-1:0] = r_r.tsel;
				ADDR_RESLO: r_nxt.rd = r_r.result[DATA_W-1:0];
				ADDR_RESHI: r_nxt.rd[RES_W-DATA_W-1:0] =
					r_r.result[RES_W-1:DATA_W];
				ADDR_STAT:  r_nxt.rd[STAT_W-1:0] = r_r.stat;
				ADDR_MASK:  r_nxt.rd[STAT_W-1:0] = r_r.mask;
				ADDR_SLEEP: r_nxt.rd[SLEEP_BIT] = r_r.sleepMode;
				default:    r_nxt.rd = ZERO_BYTE;
			endcase
		end
		if (isRd(bus, ADDR_STAT)) begin
			r_nxt.stat = ev;
		end else begin
			r_nxt.stat = r_r.stat | ev;
		end
		r_nxt.power = r_nxt.convOn && !r_nxt.powerDown;
		r_nxt.irq   = |(r_nxt.stat & r_nxt.mask);
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			r_r       <= '0;
			r_r.state <= CS_IDLE;
		end else begin
			r_r <= r_nxt;
		end
	end

	assign rdData      = r_r.rd;
	assign cmd.start   = r_r.start;
	assign cmd.abort   = r_r.abort;
	assign analogPower = r_r.power;
	assign wakeReq     = r_r.wake;
	assign irq         = r_r.irq;
endmodule
`default_nettype wire

// File: hdl/acc_pkg.sv
// Package of constants and types for the converter control sequencer
package acc_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 4;
	localparam int RES_W  = 12;
	localparam int TRIG_N = 4;
	localparam int SYNC_N = 3;

	// Register indices
	localparam logic [ADDR_W-1:0] ADDR_CTRL0  = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_CTRL2  = 4'h1;
	localparam logic [ADDR_W-1:0] ADDR_RESLO  = 4'h2;
	localparam logic [ADDR_W-1:0] ADDR_RESHI  = 4'h3;
	localparam logic [ADDR_W-1:0] ADDR_STAT   = 4'h4;
	localparam logic [ADDR_W-1:0] ADDR_MASK   = 4'h5;
	localparam logic [ADDR_W-1:0] ADDR_SLEEP  = 4'h6;

	// Field positions in converter_control_0
	localparam int CTRL0_ON  = 0;
	localparam int CTRL0_GO  = 1;
	localparam int CTRL0_RC  = 2;
	// Field positions in converter_control_2
	localparam int CTRL2_TSEL_LO = 0;
	localparam int TSEL_W        = 4;
	// Status / mask bits
	localparam int STAT_DONE = 0;
	localparam int STAT_ABRT = 1;
	localparam int STAT_W    = 2;
	// Sleep register bit
	localparam int SLEEP_BIT = 0;

	// Trigger source codes
	localparam logic [TSEL_W-1:0] TSEL_NONE = 4'h0;
	localparam logic [TSEL_W-1:0] TSEL_CCU1 = 4'h1;
	localparam logic [TSEL_W-1:0] TSEL_CCU2 = 4'h2;
	localparam logic [TSEL_W-1:0] TSEL_PSC1 = 4'h3;
	localparam logic [TSEL_W-1:0] TSEL_PSC2 = 4'h4;

	// One instruction cycle is four system clocks
	localparam int INSN_CYCLES = 4;
	localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;

	typedef enum logic [1:0] {
		CS_IDLE,
		CS_DELAY,
		CS_BUSY
	} acc_state_type;

	typedef struct packed {
		logic              wrEn;
		logic              rdEn;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wrData;
	} acc_bus_type;

	typedef struct packed {
		logic             start;
		logic             abort;
	} acc_cmd_type;

	typedef struct packed {
		logic             done;
		logic [RES_W-1:0] result;
	} acc_ana_type;
endpackage

// File: hdl/acc_trig_sync.sv
// Three-stage trigger synchroniser with rising edge detector
`timescale 1ns/1ps
`default_nettype none
module acc_trig_sync #(
	parameter int N = 4
) (
	input  wire logic         ref_clk,
	input  wire logic         rst_n,
	input  wire logic [N-1:0] trigIn,
	output logic      [N-1:0] trigRise
);
	import acc_pkg::*;

	typedef struct packed {
		logic [N-1:0] s1;
		logic [N-1:0] s2;
		logic [N-1:0] s3;
		logic [N-1:0] lvl;
		logic [N-1:0] rise;
	} acc_sync_type;

	acc_sync_type st_r;
	acc_sync_type st_nxt;

	// Level only moves when stage two and three agree
	always_comb begin
		st_nxt    = st_r;
		st_nxt.s1 = trigIn;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		for (int i = 0; i < N; i++) begin
			if (st_r.s2[i] == st_r.s3[i]) begin
				st_nxt.lvl[i] = st_r.s3[i];
			end
		end
		st_nxt.rise = st_nxt.lvl & ~st_r.lvl;
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign trigRise = st_r.rise;
endmodule
`default_nettype wire

// File: test/acc_afe_model.sv
// Analog front end model: answers a start after a set latency
`timescale 1ns/1ps
`default_nettype none
module acc_afe_model
	import acc_pkg::*;
(
	input  wire logic                 ref_clk,
	input  wire logic                 rst_n,
	input  wire acc_pkg::acc_cmd_type cmd,
	input  wire logic [7:0]           lat,
	input  wire logic [acc_pkg::RES_W-1:0] val,
	output var acc_pkg::acc_ana_type  ana
);
	int cnt = 0;
	initial ana = '0;
	// Result lines carry junk outside the done pulse, never a stale value
	always @(posedge ref_clk) begin
		if (!rst_n || cmd.abort)
			cnt <= 0;
		else if (cmd.start)
			cnt <= int'(lat);
		else if (cnt > 0)
			cnt <= cnt - 1;
		ana.done <= rst_n && cnt == 1;
		ana.result <= cnt == 1 ? val : ~val;
	end
endmodule
`default_nettype wire

// File: test/acc_conv_ctrl_asserts.sv
// Port assertions for the converter control sequencer
`timescale 1ns/1ps
`default_nettype none
module acc_conv_ctrl_asserts
	import acc_pkg::*;
#(
	parameter int DELAY_CYC = 4
) (
	input wire logic                       ref_clk,
	input wire logic                       rst_n,
	input wire acc_pkg::acc_bus_type       bus,
	input wire logic [acc_pkg::DATA_W-1:0] rdData,
	input wire acc_pkg::acc_ana_type       ana,
	input wire acc_pkg::acc_cmd_type       cmd,
	input wire logic                       analogPower,
	input wire logic                       wakeReq,
	input wire logic                       irq
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	logic acc;
	logic goWr;
	logic goFast;
	logic goSlow;
	assign acc = bus.rdEn || bus.wrEn;
	assign goWr = bus.wrEn && bus.addr == ADDR_CTRL0 && analogPower
		&& bus.wrData[1:0] == 2'b11;
	assign goFast = goWr && !bus.wrData[2];
	assign goSlow = goWr && bus.wrData[2];
	chk_reset_quiet: assert property (disable iff (1'b0)
		!rst_n |=> !analogPower && !irq && !wakeReq && cmd == '0)
		else $error("outputs live after reset");
	chk_start_on: assert property (cmd.start |-> analogPower)
		else $error("start while converter off");
	chk_go_start: assert property (goFast |=> cmd.start)
		else $error("go write gave no start");
	chk_rc_delay: assert property (
		goSlow |=> !cmd.start ##DELAY_CYC cmd.start)
		else $error("delayed start at wrong cycle");
	chk_abort_src: assert property (
		cmd.abort |-> $past(acc) || $past(acc, 2))
		else $error("abort without a write");
	chk_wake_done: assert property (
		wakeReq |-> $past(ana.done) || $past(ana.done, 2))
		else $error("wake without completion");
	chk_power_off: assert property ($fell(analogPower) |->
		$past(acc) || $past(acc, 2) || $past(ana.done) || $past(ana.done, 2))
		else $error("power dropped without cause");
	chk_irq_hold: assert property (
		$fell(irq) |-> $past(acc) || $past(acc, 2))
		else $error("interrupt dropped without access");
endmodule
`default_nettype wire

// File: test/acc_conv_ctrl_bench.sv
// Self-checking bench for the converter control sequencer
`timescale 1ns/1ps
`default_nettype none
module acc_conv_ctrl_bench;
	import acc_pkg::*;
	localparam int DLY = 4;
	logic        ref_clk = 0;
	logic        rst_n = 0;
	logic [3:0]  trig = '0;
	logic [7:0]  lat = 8'h0c;
	logic [11:0] val = 12'h000;
	acc_bus_type bus = '0;
	acc_ana_type ana;
	acc_cmd_type cmd;
	logic [7:0]  rdData;
	logic        analogPower;
	logic        wakeReq;
	logic        irq;
	int mismatches = 0;
	int samples_checked = 0;
	int cyc = 0;
	int seed = 54959;
	int n;
	int n0;
	int wk;
	always #5 ref_clk = ~ref_clk;
	acc_conv_ctrl #(.DELAY_CYC(DLY)) i_acc_conv_ctrl (.ref_clk(ref_clk),
		.rst_n(rst_n), .bus(bus), .rdData(rdData), .trigCcu1(trig[0]),
		.trigCcu2(trig[1]), .trigPsc1(trig[2]), .trigPsc2(trig[3]),
		.ana(ana), .cmd(cmd), .analogPower(analogPower),
		.wakeReq(wakeReq), .irq(irq));
	acc_afe_model i_acc_afe_model (.ref_clk(ref_clk), .rst_n(rst_n),
		.cmd(cmd), .lat(lat), .val(val), .ana(ana));
	task end_of_test;
		if (mismatches == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			mismatches++;
			end_of_test;
		end
	end
	task chk(input logic [11:0] s, e);
		samples_checked++;
		if (s !== e) begin
			mismatches++;
			$display("[FAIL] %0t seen %h wanted %h", $time, s, e);
		end
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		bus <= '{1'b1, 1'b0, a, d};
		@(posedge ref_clk);
		bus.wrEn <= 1'b0;
	endtask
	task rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		bus <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge ref_clk);
		bus.rdEn <= 1'b0;
		@(negedge ref_clk);
		chk({4'h0, rdData}, {4'h0, e});
	endtask
	task automatic waitStart(output int c);
		c = 0;
		while (cmd.start !== 1'b1 && c < 12) begin
			@(negedge ref_clk);
			c++;
		end
	endtask
	task automatic conv(input logic [7:0] d, output int c);
		val = 12'($random(seed));
		lat = 8'(12 + {$random(seed)} % 8);
		wr(ADDR_CTRL0, d);
		waitStart(c);
		rd(ADDR_RESLO, 8'h00);
		repeat (24) @(posedge ref_clk);
		rd(ADDR_RESLO, val[7:0]);
		rd(ADDR_RESHI, {4'h0, val[11:8]});
		rd(ADDR_CTRL0, d & 8'hfd);
	endtask
	initial begin
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'b1;
		for (int a = 0; a < 8; a++)
			rd(4'(a), 8'h00);
		wr(ADDR_CTRL0, 8'h02);
		rd(ADDR_CTRL0, 8'h00);
		wr(ADDR_MASK, 8'h03);
		// Enable in its own access before the first go that can start a conversion
		wr(ADDR_CTRL0, 8'h01);
		conv(8'h03, n0);
		chk(12'(irq), 12'h001);
		rd(ADDR_STAT, 8'h01);
		conv(8'h07, n);
		chk(12'(n - n0), 12'(DLY));
		rd(ADDR_STAT, 8'h01);
		@(negedge ref_clk);
		chk(12'(irq), 12'h000);
		wr(ADDR_CTRL0, 8'h03);
		wr(ADDR_CTRL0, 8'h01);
		@(negedge ref_clk);
		chk(12'(cmd.abort), 12'h001);
		repeat (24) @(posedge ref_clk);
		rd(ADDR_STAT, 8'h02);
		// The aborted run must leave the earlier result in place
		rd(ADDR_RESLO, val[7:0]);
		rd(ADDR_RESHI, {4'h0, val[11:8]});
		for (int s = 0; s < 5; s++) begin
			wr(ADDR_CTRL2, 8'(s));
			for (int t = 0; t < 4; t++) begin
				// Edges held long and spaced wide for slow sources
				@(posedge ref_clk);
				trig[t] <= 1'b1;
				waitStart(n);
				chk(12'(n < 12), 12'(s == t + 1));
				@(posedge ref_clk);
				trig <= '0;
				repeat (24) @(posedge ref_clk);
				rd(ADDR_STAT, s == t + 1 ? 8'h01 : 8'h00);
			end
		end
		for (int i = 0; i < 3; i++) begin
			wr(ADDR_MASK, 8'(i == 0));
			wr(ADDR_CTRL0, i == 2 ? 8'h03 : 8'h07);
			wr(ADDR_SLEEP, 8'h01);
			wk = 0;
			repeat (24) begin
				@(negedge ref_clk);
				if (wakeReq === 1'b1)
					wk++;
			end
			chk(12'(wk), 12'(i == 0));
			chk(12'(analogPower), 12'(i == 0));
			rd(ADDR_CTRL0, i == 2 ? 8'h01 : 8'h05);
			rd(ADDR_STAT, i == 2 ? 8'h02 : 8'h01);
			wr(ADDR_SLEEP, 8'h00);
			wr(ADDR_CTRL0, 8'h01);
		end
		wr(ADDR_CTRL0, 8'h03);
		@(posedge ref_clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		rd(ADDR_CTRL0, 8'h00);
		rd(ADDR_MASK, 8'h00);
		end_of_test;
	end
endmodule
bind acc_conv_ctrl acc_conv_ctrl_asserts #(.DELAY_CYC(DELAY_CYC)) i_chk (
	.ref_clk(ref_clk), .rst_n(rst_n), .bus(bus), .rdData(rdData),
	.ana(ana), .cmd(cmd), .analogPower(analogPower),
	.wakeReq(wakeReq), .irq(irq));
`default_nettype wire
